// *** src/twm_consts.vh ***
// Constants, timing counts and state codes for the two-wire bus master.
// Overview of operation
// - SDA changes only while SCL is low
// - START, REPEATED START, STOP: SDA edge, SCL high
// - Bus busy from START until STOP
// - Repeated start keeps bus busy until STOP
// - Address packet: seven bits, direction, acknowledge
// - Direction one reads, zero writes
// - Addressed slave acknowledges low in ninth period
// - After address NACK, master sends STOP
// - Bytes shifted out most significant bit first
// - All-zero address is general call, write only
// - Never send general call with read bit
// - Reserved addresses 1111xxx are never used
// - Data packet: byte plus acknowledge bit
// - Master drives SCL, START and STOP; receiver acknowledges
// - Receiver answers final byte with NACK
// - START then STOP without address is illegal
// - Master waits while slave stretches SCL low
// - Competing masters use identical packet composition
// - Device clock at least sixteen times SCL
`ifndef TWM_CONSTS_VH
`define TWM_CONSTS_VH

`define TWM_CLK_MHZ      25
`define TWM_T_LOW_NS     5000
`define TWM_T_HIGH_NS    5000
`define TWM_T_LOW_CYC    ((`TWM_T_LOW_NS * `TWM_CLK_MHZ + 999) / 1000)
`define TWM_T_HIGH_CYC   ((`TWM_T_HIGH_NS * `TWM_CLK_MHZ + 999) / 1000)
`define TWM_LOW_HALF     (`TWM_T_LOW_CYC / 2)

`define TWM_FIFO_WIDTH   8
`define TWM_FIFO_DEPTH   16
`define TWM_FIFO_AW      4

`define TWM_GCALL_ADDR   7'h00
`define TWM_RSVD_TOP     4'hF
`define TWM_ACK_BIT      4'h8

`define TWM_S_IDLE       4'h0
`define TWM_S_START      4'h1
`define TWM_S_LOW        4'h2
`define TWM_S_RISE       4'h3
`define TWM_S_HIGH       4'h4
`define TWM_S_STOP_LOW   4'h5
`define TWM_S_STOP_RISE  4'h6
`define TWM_S_STOP_HIGH  4'h7
`define TWM_S_BUF        4'h8
`define TWM_S_RS_LOW     4'h9
`define TWM_S_RS_RISE    4'hA
`define TWM_S_RS_HIGH    4'hB
`define TWM_S_PARK       4'hC

`endif

// *** src/twm_sync.v ***
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module twm_sync (
  input  wire sys_clk,
  input  wire rst_b,
  input  wire pin_in,
  output reg  level_r
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      s1_r    <= 1'b1;
      s2_r    <= 1'b1;
      s3_r    <= 1'b1;
      level_r <= 1'b1;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end
endmodule

// *** src/twm_fifo.v ***
// Write-data FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module twm_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             sys_clk,
  input  wire             rst_b,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output reg              in_ready,
  output wire [WIDTH-1:0] out_data,
  output reg              out_valid,
  input  wire             out_ready
);
  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wp_r;
  reg  [AW-1:0]    rp_r;
  reg  [AW:0]      cnt_r;
  reg  [AW:0]      cnt_nxt;
  wire             push;
  wire             pop;

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign out_data = mem[rp_r];

  always @* begin
    cnt_nxt = cnt_r;
    if (push & ~pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop & ~push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always @(posedge sys_clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  // Flags are registered from the next count so full and empty stay exact.
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      wp_r      <= {AW{1'b0}};
      rp_r      <= {AW{1'b0}};
      cnt_r     <= {(AW+1){1'b0}};
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r     <= cnt_nxt;
      in_ready  <= (cnt_nxt != DEPTH[AW:0]);
      out_valid <= (cnt_nxt != {(AW+1){1'b0}});
    end
  end
endmodule

// *** src/twm_master.v ***
// Two-wire bus master that drives a slave device through its SCL and SDA pins.
`timescale 1ns/1ps
`include "twm_consts.vh"
module twm_master (
  input  wire       sys_clk,
  input  wire       rst_b,
  input  wire       cmd_valid,
  output reg        cmd_ready,
  input  wire [6:0] cmd_addr,
  input  wire       cmd_read,
  input  wire [7:0] cmd_len,
  input  wire       cmd_hold,
  input  wire [7:0] wr_data,
  input  wire       wr_valid,
  output wire       wr_ready,
  output reg  [7:0] rd_data,
  output reg        rd_valid,
  output reg        done,
  output reg        nack_err,
  output reg        arb_lost,
  output reg        cmd_err,
  output reg        bus_busy,
  input  wire       scl_in,
  output reg        scl_out,
  output reg        scl_oe_b,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe_b
);
  // Counts are worked out as integers and cut to the counter width on purpose.
  localparam integer T_LOW_W  = `TWM_T_LOW_CYC;
  localparam integer T_HIGH_W = `TWM_T_HIGH_CYC;
  localparam integer L_HALF_W = `TWM_LOW_HALF;
  localparam [7:0]   T_LOW    = T_LOW_W[7:0];
  localparam [7:0]   T_HIGH   = T_HIGH_W[7:0];
  localparam [7:0]   L_HALF   = L_HALF_W[7:0];

  wire       scl_f;
  wire       sda_f;
  wire [7:0] fifo_data;
  wire       fifo_valid;
  reg        fifo_pop;
  reg        sda_p_r;
  reg  [3:0] state_r;
  reg  [7:0] cnt_r;
  reg  [3:0] bit_r;
  reg  [7:0] sh_r;
  reg  [7:0] rx_r;
  reg  [7:0] left_r;
  reg        addr_ph_r;
  reg        read_r;
  reg        hold_r;
  wire       start_seen;
  wire       stop_seen;
  wire       need_load;
  wire       tx_mode;
  wire       tx_bit;
  wire       cmd_bad;
  wire       can_take;
  wire       take;
  wire       arb_hit;

  twm_sync u_scl_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .pin_in  (scl_in),
    .level_r (scl_f)
  );

  twm_sync u_sda_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .pin_in  (sda_in),
    .level_r (sda_f)
  );

  twm_fifo #(
    .WIDTH (`TWM_FIFO_WIDTH),
    .DEPTH (`TWM_FIFO_DEPTH),
    .AW    (`TWM_FIFO_AW)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .in_data   (wr_data),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  assign start_seen = scl_f & sda_p_r & ~sda_f;
  assign stop_seen  = scl_f & ~sda_p_r & sda_f;

  // A write byte is fetched at the first bit of each data packet of a write transfer.
  assign need_load = ~read_r & ~addr_ph_r & (bit_r == 4'h0);
  assign tx_mode   = addr_ph_r | ~read_r;
  // Receiving: release data bits, ACK low except NACK on the last byte.
  assign tx_bit = (bit_r == `TWM_ACK_BIT) ? (tx_mode | (left_r == 8'h01)) :
                  (tx_mode ? (need_load ? fifo_data[7] : sh_r[7]) : 1'b1);

  // Empty transfers, general call reads and reserved addresses are refused.
  assign cmd_bad = (cmd_len == 8'h00) |
                   ((cmd_addr == `TWM_GCALL_ADDR) & cmd_read) |
                   (cmd_addr[6:3] == `TWM_RSVD_TOP);
  assign can_take = ((state_r == `TWM_S_IDLE) & ~bus_busy & scl_f & sda_f) |
                    (state_r == `TWM_S_PARK);
  assign take = cmd_valid & cmd_ready & can_take;
  // Every bit we send except acknowledge bits is checked, data bits too, so rivals keep arbitrating to the end.
  assign arb_hit = tx_mode & (bit_r != `TWM_ACK_BIT) & sda_oe_b & ~sda_f;

  always @* begin
    fifo_pop = (state_r == `TWM_S_LOW) & (cnt_r == L_HALF) & need_load & fifo_valid;
  end

  // Busy follows the filtered lines, so frames of other masters hold us off as well.
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      sda_p_r  <= 1'b1;
      bus_busy <= 1'b0;
    end else begin
      sda_p_r <= sda_f;
      if (start_seen) begin
        bus_busy <= 1'b1;
      end else if (stop_seen) begin
        bus_busy <= 1'b0;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      state_r   <= `TWM_S_IDLE;
      cnt_r     <= 8'h00;
      bit_r     <= 4'h0;
      sh_r      <= 8'h00;
      rx_r      <= 8'h00;
      left_r    <= 8'h00;
      addr_ph_r <= 1'b0;
      read_r    <= 1'b0;
      hold_r    <= 1'b0;
      cmd_ready <= 1'b0;
      rd_data   <= 8'h00;
      rd_valid  <= 1'b0;
      done      <= 1'b0;
      nack_err  <= 1'b0;
      arb_lost  <= 1'b0;
      cmd_err   <= 1'b0;
      scl_out   <= 1'b0;
      sda_out   <= 1'b0;
      scl_oe_b  <= 1'b1;
      sda_oe_b  <= 1'b1;
    end else begin
      rd_valid  <= 1'b0;
      done      <= 1'b0;
      arb_lost  <= 1'b0;
      cmd_err   <= 1'b0;
      cmd_ready <= can_take & ~take;
      // Open-drain pins only ever pull low; the enables alone move the lines.
      scl_out   <= 1'b0;
      sda_out   <= 1'b0;
      // The packet layout is fixed once taken, so rivals with the same layout can arbitrate.
      if (take) begin
        cmd_ready <= 1'b0;
        if (cmd_bad) begin
          cmd_err <= 1'b1;
        end else begin
          sh_r      <= {cmd_addr, cmd_read};
          read_r    <= cmd_read;
          hold_r    <= cmd_hold;
          left_r    <= cmd_len;
          nack_err  <= 1'b0;
          addr_ph_r <= 1'b1;
          bit_r     <= 4'h0;
          if (state_r == `TWM_S_PARK) begin
            state_r <= `TWM_S_RS_LOW;
            cnt_r   <= T_LOW;
          end else begin
            sda_oe_b <= 1'b0;
            state_r  <= `TWM_S_START;
            cnt_r    <= T_HIGH;
          end
        end
      end else begin
        case (state_r)
          `TWM_S_IDLE: begin
            scl_oe_b <= 1'b1;
            sda_oe_b <= 1'b1;
          end
          `TWM_S_START: begin
            if (cnt_r == 8'h00) begin
              scl_oe_b <= 1'b0;
              cnt_r    <= T_LOW;
              state_r  <= `TWM_S_LOW;
            end else begin
              cnt_r <= cnt_r - 8'h01;
            end
          end
          `TWM_S_LOW: begin
            // SDA moves only at mid-low, well away from either SCL edge.
            // An empty FIFO stalls here with SCL held low until data arrives.
            if (cnt_r == L_HALF) begin
              if (~need_load | fifo_valid) begin
                sda_oe_b <= tx_bit;
                if (need_load) begin
                  sh_r <= fifo_data;
                end
                cnt_r <= cnt_r - 8'h01;
              end
            end else if (cnt_r == 8'h00) begin
              scl_oe_b <= 1'b1;
              state_r  <= `TWM_S_RISE;
            end else begin
              cnt_r <= cnt_r - 8'h01;
            end
          end
          `TWM_S_RISE: begin
            // A stretching slave keeps us here; the high phase is timed from the seen edge.
            if (scl_f) begin
              cnt_r   <= T_HIGH;
              state_r <= `TWM_S_HIGH;
            end
          end
          `TWM_S_HIGH: begin
            if (arb_hit) begin
              // Another master drove a zero against our one.
              sda_oe_b <= 1'b1;
              scl_oe_b <= 1'b1;
              arb_lost <= 1'b1;
              state_r  <= `TWM_S_IDLE;
            end else if ((cnt_r == 8'h00) | ~scl_f) begin
              // Data is taken at the end of the high phase, long after the inputs settled.
              scl_oe_b <= 1'b0;
              cnt_r    <= T_LOW;
              state_r  <= `TWM_S_LOW;
              if (bit_r != `TWM_ACK_BIT) begin
                rx_r  <= {rx_r[6:0], sda_f};
                sh_r  <= {sh_r[6:0], 1'b0};
                bit_r <= bit_r + 4'h1;
              end else begin
                bit_r <= 4'h0;
                if (addr_ph_r) begin
                  addr_ph_r <= 1'b0;
                  if (sda_f) begin
                    nack_err <= 1'b1;
                    state_r  <= `TWM_S_STOP_LOW;
                  end
                end else begin
                  left_r <= left_r - 8'h01;
                  if (read_r) begin
                    rd_data  <= rx_r;
                    rd_valid <= 1'b1;
                  end
                  if (~read_r & sda_f) begin
                    nack_err <= 1'b1;
                    state_r  <= `TWM_S_STOP_LOW;
                  end else if (left_r == 8'h01) begin
                    if (hold_r) begin
                      done    <= 1'b1;
                      state_r <= `TWM_S_PARK;
                    end else begin
                      state_r <= `TWM_S_STOP_LOW;
                    end
                  end
                end
              end
            end else begin
              cnt_r <= cnt_r - 8'h01;
            end
          end
          `TWM_S_STOP_LOW: begin
            // SDA is pulled low at mid-low so that the STOP edge can follow the SCL rise.
            if (cnt_r == L_HALF) begin
              sda_oe_b <= 1'b0;
              cnt_r    <= cnt_r - 8'h01;
            end else if (cnt_r == 8'h00) begin
              scl_oe_b <= 1'b1;
              state_r  <= `TWM_S_STOP_RISE;
            end else begin
              cnt_r <= cnt_r - 8'h01;
            end
          end
          `TWM_S_STOP_RISE: begin
            if (scl_f) begin
              cnt_r   <= T_HIGH;
              state_r <= `TWM_S_STOP_HIGH;
            end
          end
          `TWM_S_STOP_HIGH: begin
            if (cnt_r == 8'h00) begin
              sda_oe_b <= 1'b1;
              cnt_r    <= T_HIGH;
              state_r  <= `TWM_S_BUF;
            end else begin
              cnt_r <= cnt_r - 8'h01;
            end
          end
          `TWM_S_BUF: begin
            // Bus free time after STOP reuses the high count before done is given.
            if (cnt_r == 8'h00) begin
              done    <= 1'b1;
              state_r <= `TWM_S_IDLE;
            end else begin
              cnt_r <= cnt_r - 8'h01;
            end
          end
          `TWM_S_RS_LOW: begin
            // SDA is released at mid-low so that the repeated START finds it high.
            if (cnt_r == L_HALF) begin
              sda_oe_b <= 1'b1;
              cnt_r    <= cnt_r - 8'h01;
            end else if (cnt_r == 8'h00) begin
              scl_oe_b <= 1'b1;
              state_r  <= `TWM_S_RS_RISE;
            end else begin
              cnt_r <= cnt_r - 8'h01;
            end
          end
          `TWM_S_RS_RISE: begin
            if (scl_f) begin
              cnt_r   <= T_HIGH;
              state_r <= `TWM_S_RS_HIGH;
            end
          end
          `TWM_S_RS_HIGH: begin
            if (cnt_r == 8'h00) begin
              sda_oe_b <= 1'b0;
              cnt_r    <= T_HIGH;
              state_r  <= `TWM_S_START;
            end else begin
              cnt_r <= cnt_r - 8'h01;
            end
          end
          `TWM_S_PARK: begin
            // Bus stays owned; SCL low pauses the slave until the next command.
            scl_oe_b <= 1'b0;
            sda_oe_b <= 1'b1;
          end
          default: begin
            state_r <= `TWM_S_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// *** sim/twm_master_assertions.sv ***
// Concurrent protocol checks on the two-wire bus master ports.
`timescale 1ns/1ps
module twm_chk (
  input wire       sys_clk,
  input wire       rst_b,
  input wire       cmd_valid,
  input wire       cmd_ready,
  input wire [6:0] cmd_addr,
  input wire       cmd_read,
  input wire [7:0] cmd_len,
  input wire       cmd_err,
  input wire       arb_lost,
  input wire       bus_busy,
  input wire       scl_in,
  input wire       scl_oe_b,
  input wire       sda_in,
  input wire       sda_oe_b
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire take = cmd_valid && cmd_ready;
  wire bad  = cmd_len == 8'h00 || (cmd_addr == 7'h00 && cmd_read) || cmd_addr[6:3] == 4'hF;
  property p_rdy;
    take |=> !cmd_ready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready stayed high after take");
  property p_refuse;
    take && bad |=> cmd_err;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad command not refused");
  property p_quiet;
    take && bad |=> sda_oe_b [*8];
  endproperty
  a_quiet: assert property (p_quiet) else $error("refused command drove the bus");
  property p_busy;
    !scl_oe_b |-> bus_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("clock driven while bus idle");
  property p_start;
    scl_in && $past(scl_in) && $fell(sda_in) |-> ##[1:6] bus_busy;
  endproperty
  a_start: assert property (p_start) else $error("start not seen");
  property p_stop;
    scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:6] !bus_busy;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not seen");
  property p_high;
    $rose(scl_in) && bus_busy |-> scl_oe_b [*8];
  endproperty
  a_high: assert property (p_high) else $error("high phase cut short");
  property p_arb;
    arb_lost |-> sda_oe_b && $past(sda_oe_b, 2) ##1 sda_oe_b [*4];
  endproperty
  a_arb: assert property (p_arb) else $error("data held after lost arbitration");
endmodule

// *** sim/twm_slave.sv ***
// Behavioural slave device on the open-drain two-wire bus.
`timescale 1ns/1ps
module twm_slave #(
  parameter [6:0] ADDR = 7'h2A
) (
  input  wire       scl,
  input  wire       sda,
  input  wire       gc_en,
  input  wire [7:0] stretch,
  output reg        scl_rel,
  output reg        sda_rel
);
  reg [7:0] rx [0:63];
  reg [7:0] sh;
  integer   n;
  integer   i;
  integer   k;
  event     go;
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
    n = 0;
  end
  task get_byte;
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge scl);
      sh = {sh[6:0], sda};
      @(negedge scl);
    end
  endtask
  task ack;
    begin
      sda_rel = 1'b0;
      @(negedge scl);
      sda_rel = 1'b1;
      scl_rel = 1'b0;
      #(stretch * 40);
      scl_rel = 1'b1;
    end
  endtask
  // A new start aborts whatever frame was running, so a repeated start resyncs the model.
  always @(negedge sda) if (scl === 1'b1) begin
    disable xfer;
    sda_rel = 1'b1;
    scl_rel = 1'b1;
    #1 ->go;
  end
  always @(posedge sda) if (scl === 1'b1) disable xfer;
  always @(go) begin : xfer
    get_byte;
    rx[n] = sh;
    n = n + 1;
    if (sh[7:1] == ADDR || (sh[7:1] == 7'h00 && !sh[0] && gc_en)) begin
      ack;
      if (sh[0]) begin
        for (k = 0; k < 256; k = k + 1) begin
          sh = 8'h35 + k[7:0];
          for (i = 0; i < 8; i = i + 1) begin
            sda_rel = sh[7 - i];
            @(negedge scl);
          end
          sda_rel = 1'b1;
          @(posedge scl);
          if (sda) k = 256;
          @(negedge scl);
        end
      end else
        forever begin
          get_byte;
          rx[n] = sh;
          n = n + 1;
          ack;
        end
    end
  end
endmodule

// *** sim/twm_master_tb.sv ***
// Self-checking bench for the two-wire bus master.
`timescale 1ns/1ps
module twm_master_tb;
  reg        sys_clk;
  reg        rst_b;
  reg        cmd_valid;
  reg  [6:0] cmd_addr;
  reg        cmd_read;
  reg  [7:0] cmd_len;
  reg        cmd_hold;
  reg  [7:0] wr_data;
  reg        wr_valid;
  reg        arb_n;
  reg        gc_en;
  reg  [7:0] stretch;
  reg  [7:0] rq [0:7];
  integer    rn;
  integer    b;
  integer    bad_count;
  integer    compares;
  wire       cmd_ready;
  wire       wr_ready;
  wire [7:0] rd_data;
  wire       rd_valid;
  wire       done;
  wire       nack_err;
  wire       arb_lost;
  wire       cmd_err;
  wire       bus_busy;
  wire       scl_oe_b;
  wire       sda_oe_b;
  wire       s_scl;
  wire       s_sda;
  wire       scl_o;
  wire       sda_o;
  // Pull-ups make a released line high; any party driving low wins.
  wire       scl = scl_oe_b & s_scl;
  wire       sda = sda_oe_b & s_sda & arb_n;
  twm_master u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_read(cmd_read), .cmd_len(cmd_len),
    .cmd_hold(cmd_hold), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .nack_err(nack_err),
    .arb_lost(arb_lost), .cmd_err(cmd_err), .bus_busy(bus_busy), .scl_in(scl),
    .scl_out(scl_o), .scl_oe_b(scl_oe_b), .sda_in(sda), .sda_out(sda_o), .sda_oe_b(sda_oe_b));
  twm_slave #(.ADDR(7'h2A)) u_slv (.scl(scl), .sda(sda), .gc_en(gc_en),
    .stretch(stretch), .scl_rel(s_scl), .sda_rel(s_sda));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (rd_valid === 1'b1) begin
    rq[rn] = rd_data;
    rn = rn + 1;
  end
  task chk(input [127:0] nm, input [7:0] e, input [7:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task cmd(input [6:0] a, input r, input [7:0] l, input h);
    integer k;
    begin
      cmd_addr <= a;
      cmd_read <= r;
      cmd_len <= l;
      cmd_hold <= h;
      cmd_valid <= 1'b1;
      b = u_slv.n;
      @(posedge sys_clk);
      for (k = 0; k < 5000 && cmd_ready !== 1'b1; k = k + 1)
        @(posedge sys_clk);
      chk("cmd_ready", 1, cmd_ready);
      cmd_valid <= 1'b0;
    end
  endtask
  task wdone;
    integer k;
    begin
      for (k = 0; k < 60000 && done !== 1'b1; k = k + 1)
        @(posedge sys_clk);
      chk("done", 1, done);
    end
  endtask
  task push(input [7:0] d);
    begin
      wr_data <= d;
      wr_valid <= 1'b1;
      @(posedge sys_clk);
      wr_valid <= 1'b0;
    end
  endtask
  task idle_chk;
    begin
      repeat (8) @(posedge sys_clk);
      chk("bus_busy", 0, bus_busy);
      chk("pin drive", 8'h00, {scl_o, sda_o});
    end
  endtask
  task t_bad;
    integer i;
    for (i = 0; i < 3; i = i + 1) begin
      cmd(i == 0 ? 7'h2A : (i == 1 ? 7'h00 : 7'h7B), i == 1, i == 0 ? 8'h00 : 8'h01, 1'b0);
      @(posedge sys_clk);
      chk("cmd_err", 1, cmd_err);
      idle_chk;
      chk("slave frames", b, u_slv.n);
    end
  endtask
  task t_nack;
    begin
      cmd(7'h11, 1'b0, 8'h01, 1'b0);
      wdone;
      chk("nack_err", 1, nack_err);
      chk("addr byte", 8'h22, u_slv.rx[b]);
      idle_chk;
    end
  endtask
  task t_gc;
    begin
      gc_en <= 1'b1;
      push(8'h5C);
      cmd(7'h00, 1'b0, 8'h01, 1'b0);
      wdone;
      chk("nack_err", 0, nack_err);
      chk("gc data", 8'h5C, u_slv.rx[b + 1]);
      idle_chk;
    end
  endtask
  task t_rs;
    begin
      push(8'h3C);
      cmd(7'h2A, 1'b0, 8'h01, 1'b1);
      wdone;
      chk("parked busy", 1, bus_busy);
      rn = 0;
      cmd(7'h2A, 1'b1, 8'h02, 1'b0);
      wdone;
      chk("rs read addr", 8'h55, u_slv.rx[b]);
      chk("rd byte 0", 8'h35, rq[0]);
      chk("rd byte 1", 8'h36, rq[1]);
      idle_chk;
    end
  endtask
  task t_fifo;
    integer i;
    begin
      stretch <= 8'hC8;
      wr_valid <= 1'b1;
      for (i = 0; i < 17; i = i + 1) begin
        wr_data <= 8'h80 + i[7:0];
        @(posedge sys_clk);
      end
      wr_valid <= 1'b0;
      chk("wr_ready full", 0, wr_ready);
      cmd(7'h2A, 1'b0, 8'h10, 1'b0);
      wdone;
      chk("wr addr", 8'h54, u_slv.rx[b]);
      for (i = 0; i < 16; i = i + 1)
        chk("wr data", 8'h80 + i[7:0], u_slv.rx[b + 1 + i]);
      chk("wr_ready empty", 1, wr_ready);
      idle_chk;
    end
  endtask
  task t_arb;
    integer k;
    begin
      cmd(7'h50, 1'b0, 8'h01, 1'b0);
      @(negedge scl);
      @(posedge sys_clk);
      arb_n <= 1'b0;
      for (k = 0; k < 2000 && arb_lost !== 1'b1; k = k + 1)
        @(posedge sys_clk);
      chk("arb_lost", 1, arb_lost);
      arb_n <= 1'b1;
      idle_chk;
    end
  endtask
  task end_of_test;
    begin
      $display("Compares %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_addr = 7'h00;
    cmd_read = 1'b0;
    cmd_len = 8'h00;
    cmd_hold = 1'b0;
    wr_data = 8'h00;
    wr_valid = 1'b0;
    arb_n = 1'b1;
    gc_en = 1'b0;
    stretch = 8'h00;
    bad_count = 0;
    compares = 0;
    rn = 0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge sys_clk);
    t_bad;
    t_nack;
    t_gc;
    t_rs;
    t_fifo;
    t_arb;
    end_of_test;
  end
  // About twenty-six packets of some 2400 cycles each fit well inside these 90000 cycles.
  initial begin
    #3600000;
    bad_count = bad_count + 1;
    end_of_test;
  end
endmodule
bind twm_master twm_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_read(cmd_read), .cmd_len(cmd_len),
  .cmd_err(cmd_err), .arb_lost(arb_lost), .bus_busy(bus_busy), .scl_in(scl_in),
  .scl_oe_b(scl_oe_b), .sda_in(sda_in), .sda_oe_b(sda_oe_b));
